// ### core/lprc_pkg.sv
// Contract
// - Ambient result high byte 85h, low 86h
// - Ambient result bytes ignore host writes
// - Proximity result high byte 87h, low 88h
// - Proximity result bytes ignore host writes
// - Bits 7:5 persistence, 2^n consecutive, default 000
// - Bit 1 enables threshold interrupt
// - Bits 3/2 enable proximity/ambient ready interrupts
// - Select bit clear compares proximity results
// - Select bit set compares ambient results
// - Interrupt control byte 89h reads back
// - Low 8Ah/8Bh, high 8Ch/8Dh thresholds, high first
// - Status flags sticky until host writes one
// - Interrupt pin low while any flag set
package lprc_pkg;

   // ----------------------------------------------------------
   // Register map
   // ----------------------------------------------------------
   localparam logic [7:0] ADDR_ALS_HI = 8'h85;
   localparam logic [7:0] ADDR_ALS_LO = 8'h86;
   localparam logic [7:0] ADDR_PROX_HI = 8'h87;
   localparam logic [7:0] ADDR_PROX_LO = 8'h88;
   localparam logic [7:0] ADDR_CTRL = 8'h89;
   localparam logic [7:0] ADDR_LOW_HI = 8'h8A;
   localparam logic [7:0] ADDR_LOW_LO = 8'h8B;
   localparam logic [7:0] ADDR_HIGH_HI = 8'h8C;
   localparam logic [7:0] ADDR_HIGH_LO = 8'h8D;
   localparam logic [7:0] ADDR_STATUS = 8'h8E;

   // ----------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------
   localparam int CTRL_PERSIST_MSB = 7;
   localparam int CTRL_PERSIST_LSB = 5;
   localparam int CTRL_PROX_RDY_EN = 3;
   localparam int CTRL_ALS_RDY_EN = 2;
   localparam int CTRL_LIMIT_EN = 1;
   localparam int CTRL_LIMIT_SEL = 0;
   localparam int STAT_PROX_RDY = 3;
   localparam int STAT_ALS_RDY = 2;
   localparam int STAT_BELOW = 1;
   localparam int STAT_ABOVE = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] LOW_TH_RST = 16'h0000;
   localparam logic [15:0] HIGH_TH_RST = 16'hFFFF;
   localparam logic [2:0] PERSIST_SINGLE = 3'h0;
   localparam logic [7:0] RUN_ONE = 8'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Arbitrary bus address value
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WR_BYTE = 3'b011,
      ST_WR_ACK = 3'b100,
      ST_RD_BYTE = 3'b101,
      ST_RD_ACK = 3'b110
   } lprc_bus_state_type;

endpackage

// ### core/lprc_limit_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lprc_limit_if;
   logic sample;
   logic above;
   logic below;
   logic enable;
   logic [2:0] persist_code;
   logic fire_above;
   logic fire_below;
   modport feed (output sample, output above, output below, output enable,
                 output persist_code, input fire_above, input fire_below);
   modport judge (input sample, input above, input below, input enable,
                  input persist_code, output fire_above, output fire_below);
endinterface
`default_nettype wire

// ### core/lprc_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module lprc_sync2 #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ### core/lprc_persist.sv
`timescale 1ns/1ns
`default_nettype none
module lprc_persist (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   lprc_limit_if.judge lim
);
   logic [7:0] run;
   logic [7:0] next_run;
   logic [7:0] target;
   logic hit;
   logic outside;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   assign target = lprc_pkg::RUN_ONE << lim.persist_code;
   assign outside = lim.above | lim.below;
   // Greater-or-equal so a shrunken setting mid-run still fires
   assign hit = ({1'b0, run} + {1'b0, lprc_pkg::RUN_ONE}) >= {1'b0, target};
   assign lim.fire_above = lim.enable & lim.sample & lim.above & hit;
   assign lim.fire_below = lim.enable & lim.sample & lim.below & hit;

   always_comb begin
      next_run = run;
      if (!lim.enable) begin
         next_run = '0;
      end else if (lim.sample) begin
         if (!outside) begin
            next_run = '0;
         end else if (hit) begin
            next_run = '0;
         end else begin
            next_run = run + lprc_pkg::RUN_ONE;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run <= '0;
      end else begin
         run <= next_run;
      end
   end

   chk_run_restart: assert property (
      lim.sample && !lim.above && !lim.below |=> run == '0)
      else $error("exceedance run not restarted by in-range sample");
   chk_single_count: assert property (
      lim.enable && lim.persist_code == lprc_pkg::PERSIST_SINGLE && lim.sample
      && (lim.above || lim.below) |-> lim.fire_above || lim.fire_below)
      else $error("count of one did not fire on first exceedance");
   chk_disabled_quiet: assert property (
      !lim.enable |-> !lim.fire_above && !lim.fire_below)
      else $error("threshold event while disabled");
endmodule
`default_nettype wire

// ### core/lprc_top.sv
`timescale 1ns/1ns
`default_nettype none
module lprc_top #(
   parameter logic [6:0] DEV_ADDR = lprc_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_b_o,
   output logic int_o,
   output logic int_oe_b_o,
   input wire logic [15:0] als_result_i,
   input wire logic als_done_i,
   input wire logic [15:0] prox_result_i,
   input wire logic prox_done_i
);
   // ----------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   lprc_sync2 #(.RST_VAL(1'b1)) u_scl_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .d_i(scl_i),
      .q_o(scl_s)
   );
   lprc_sync2 #(.RST_VAL(1'b1)) u_sda_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .d_i(sda_i),
      .q_o(sda_s)
   );

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------
   // Serial register port
   // ----------------------------------------------------------
   lprc_pkg::lprc_bus_state_type state;
   lprc_pkg::lprc_bus_state_type next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] tx;
   logic [7:0] next_tx;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic ptr_set;
   logic next_ptr_set;
   logic rw;
   logic next_rw;
   logic nack;
   logic next_nack;
   logic drive_low;
   logic next_drive_low;
   logic wr_en;
   logic next_wr_en;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic [7:0] wr_data;
   logic [7:0] next_wr_data;
   logic [7:0] rd_data;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_tx = tx;
      next_ptr = ptr;
      next_ptr_set = ptr_set;
      next_rw = rw;
      next_nack = nack;
      next_drive_low = drive_low;
      next_wr_en = 1'b0;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      if (bus_stop) begin
         next_state = lprc_pkg::ST_IDLE;
         next_drive_low = 1'b0;
      end else if (bus_start) begin
         // A repeated start keeps the pointer for a following read
         next_state = lprc_pkg::ST_ADDR;
         next_bit_cnt = '0;
         next_drive_low = 1'b0;
         next_ptr_set = 1'b0;
      end else if (scl_rise) begin
         unique case (state)
            lprc_pkg::ST_ADDR, lprc_pkg::ST_WR_BYTE: begin
               if (bit_cnt < lprc_pkg::BITS_PER_BYTE) begin
                  next_shift = {shift[6:0], sda_s};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            lprc_pkg::ST_RD_BYTE: begin
               if (bit_cnt < lprc_pkg::BITS_PER_BYTE) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            lprc_pkg::ST_RD_ACK: begin
               next_nack = sda_s;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (state)
            lprc_pkg::ST_IDLE: begin
            end
            lprc_pkg::ST_ADDR: begin
               if (bit_cnt == lprc_pkg::BITS_PER_BYTE) begin
                  if (shift[7:1] == DEV_ADDR) begin
                     next_state = lprc_pkg::ST_ADDR_ACK;
                     next_drive_low = 1'b1;
                     next_rw = shift[0];
                  end else begin
                     next_state = lprc_pkg::ST_IDLE;
                  end
               end
            end
            lprc_pkg::ST_ADDR_ACK: begin
               next_bit_cnt = '0;
               if (rw) begin
                  next_state = lprc_pkg::ST_RD_BYTE;
                  next_tx = rd_data;
                  next_drive_low = ~rd_data[7];
               end else begin
                  next_state = lprc_pkg::ST_WR_BYTE;
                  next_drive_low = 1'b0;
               end
            end
            lprc_pkg::ST_WR_BYTE: begin
               if (bit_cnt == lprc_pkg::BITS_PER_BYTE) begin
                  next_state = lprc_pkg::ST_WR_ACK;
                  next_drive_low = 1'b1;
                  if (ptr_set) begin
                     next_wr_en = 1'b1;
                     next_wr_addr = ptr;
                     next_wr_data = shift;
                     next_ptr = ptr + 8'h01;
                  end else begin
                     next_ptr = shift;
                     next_ptr_set = 1'b1;
                  end
               end
            end
            lprc_pkg::ST_WR_ACK: begin
               next_state = lprc_pkg::ST_WR_BYTE;
               next_bit_cnt = '0;
               next_drive_low = 1'b0;
            end
            lprc_pkg::ST_RD_BYTE: begin
               if (bit_cnt == lprc_pkg::BITS_PER_BYTE) begin
                  next_state = lprc_pkg::ST_RD_ACK;
                  next_drive_low = 1'b0;
                  next_ptr = ptr + 8'h01;
               end else begin
                  next_drive_low = ~tx[3'h7 - bit_cnt[2:0]];
               end
            end
            lprc_pkg::ST_RD_ACK: begin
               if (nack) begin
                  next_state = lprc_pkg::ST_IDLE;
               end else begin
                  next_state = lprc_pkg::ST_RD_BYTE;
                  next_bit_cnt = '0;
                  next_tx = rd_data;
                  next_drive_low = ~rd_data[7];
               end
            end
            default: begin
               next_state = lprc_pkg::ST_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= lprc_pkg::ST_IDLE;
         bit_cnt <= '0;
         shift <= '0;
         tx <= '0;
         ptr <= '0;
         ptr_set <= 1'b0;
         rw <= 1'b0;
         nack <= 1'b0;
         drive_low <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         tx <= next_tx;
         ptr <= next_ptr;
         ptr_set <= next_ptr_set;
         rw <= next_rw;
         nack <= next_nack;
         drive_low <= next_drive_low;
         wr_en <= next_wr_en;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_b_o = ~drive_low;

   // ----------------------------------------------------------
   // Register file
   // ----------------------------------------------------------
   logic [15:0] als_result;
   logic [15:0] next_als_result;
   logic [15:0] prox_result;
   logic [15:0] next_prox_result;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [15:0] low_th;
   logic [15:0] next_low_th;
   logic [15:0] high_th;
   logic [15:0] next_high_th;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [7:0] set_mask;
   logic [7:0] clr_mask;
   logic next_int_oe_b;
   logic int_oe_b;
   logic [15:0] cmp_value;

   lprc_limit_if lim ();

   always_comb begin
      unique case (ptr)
         lprc_pkg::ADDR_ALS_HI: rd_data = als_result[15:8];
         lprc_pkg::ADDR_ALS_LO: rd_data = als_result[7:0];
         lprc_pkg::ADDR_PROX_HI: rd_data = prox_result[15:8];
         lprc_pkg::ADDR_PROX_LO: rd_data = prox_result[7:0];
         lprc_pkg::ADDR_CTRL: rd_data = ctrl;
         lprc_pkg::ADDR_LOW_HI: rd_data = low_th[15:8];
         lprc_pkg::ADDR_LOW_LO: rd_data = low_th[7:0];
         lprc_pkg::ADDR_HIGH_HI: rd_data = high_th[15:8];
         lprc_pkg::ADDR_HIGH_LO: rd_data = high_th[7:0];
         lprc_pkg::ADDR_STATUS: rd_data = status;
         default: rd_data = lprc_pkg::READ_UNMAPPED;
      endcase
   end

   // The comparison uses the fresh result, not the stored copy
   assign cmp_value = ctrl[lprc_pkg::CTRL_LIMIT_SEL] ? als_result_i : prox_result_i;
   assign lim.sample = ctrl[lprc_pkg::CTRL_LIMIT_SEL] ? als_done_i : prox_done_i;
   assign lim.above = cmp_value > high_th;
   assign lim.below = cmp_value < low_th;
   assign lim.enable = ctrl[lprc_pkg::CTRL_LIMIT_EN];
   assign lim.persist_code = ctrl[lprc_pkg::CTRL_PERSIST_MSB:lprc_pkg::CTRL_PERSIST_LSB];

   lprc_persist u_persist (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .lim(lim)
   );

   always_comb begin
      // Host writes to result addresses fall through untouched
      next_als_result = als_done_i ? als_result_i : als_result;
      next_prox_result = prox_done_i ? prox_result_i : prox_result;
      next_ctrl = ctrl;
      next_low_th = low_th;
      next_high_th = high_th;
      clr_mask = '0;
      if (wr_en) begin
         unique case (wr_addr)
            lprc_pkg::ADDR_CTRL: next_ctrl = wr_data;
            lprc_pkg::ADDR_LOW_HI: next_low_th[15:8] = wr_data;
            lprc_pkg::ADDR_LOW_LO: next_low_th[7:0] = wr_data;
            lprc_pkg::ADDR_HIGH_HI: next_high_th[15:8] = wr_data;
            lprc_pkg::ADDR_HIGH_LO: next_high_th[7:0] = wr_data;
            lprc_pkg::ADDR_STATUS: clr_mask = wr_data;
            default: begin
            end
         endcase
      end
      set_mask = '0;
      set_mask[lprc_pkg::STAT_PROX_RDY] = prox_done_i & ctrl[lprc_pkg::CTRL_PROX_RDY_EN];
      set_mask[lprc_pkg::STAT_ALS_RDY] = als_done_i & ctrl[lprc_pkg::CTRL_ALS_RDY_EN];
      set_mask[lprc_pkg::STAT_BELOW] = lim.fire_below;
      set_mask[lprc_pkg::STAT_ABOVE] = lim.fire_above;
      // A new event beats a clear arriving in the same cycle
      next_status = (status & ~clr_mask) | set_mask;
      next_int_oe_b = ~(|next_status);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         als_result <= lprc_pkg::RESULT_RST;
         prox_result <= lprc_pkg::RESULT_RST;
         ctrl <= lprc_pkg::CTRL_RST;
         low_th <= lprc_pkg::LOW_TH_RST;
         high_th <= lprc_pkg::HIGH_TH_RST;
         status <= lprc_pkg::STATUS_RST;
         int_oe_b <= 1'b1;
      end else begin
         als_result <= next_als_result;
         prox_result <= next_prox_result;
         ctrl <= next_ctrl;
         low_th <= next_low_th;
         high_th <= next_high_th;
         status <= next_status;
         int_oe_b <= next_int_oe_b;
      end
   end

   assign int_o = 1'b0;
   assign int_oe_b_o = int_oe_b;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   chk_als_capture: assert property (
      als_done_i |=> als_result == $past(als_result_i))
      else $error("ambient result not captured");
   chk_als_readonly: assert property (
      wr_en && (wr_addr == lprc_pkg::ADDR_ALS_HI || wr_addr == lprc_pkg::ADDR_ALS_LO)
      && !als_done_i |=> $stable(als_result))
      else $error("ambient result changed by host write");
   chk_prox_capture: assert property (
      prox_done_i |=> prox_result == $past(prox_result_i))
      else $error("proximity result not captured");
   chk_prox_readonly: assert property (
      !prox_done_i |=> $stable(prox_result))
      else $error("proximity result changed without a measurement");
   chk_above_flag: assert property (
      lim.fire_above |=> status[lprc_pkg::STAT_ABOVE] && !int_oe_b_o)
      else $error("above-limit event lost");
   chk_ready_flags: assert property (
      prox_done_i && ctrl[lprc_pkg::CTRL_PROX_RDY_EN]
      |=> status[lprc_pkg::STAT_PROX_RDY])
      else $error("proximity ready flag not set");
   chk_prox_source: assert property (
      !ctrl[lprc_pkg::CTRL_LIMIT_SEL] && als_done_i && !prox_done_i |-> !lim.sample)
      else $error("ambient result compared while proximity selected");
   chk_als_source: assert property (
      ctrl[lprc_pkg::CTRL_LIMIT_SEL] && prox_done_i && !als_done_i |-> !lim.sample)
      else $error("proximity result compared while ambient selected");
   chk_ctrl_write: assert property (
      wr_en && wr_addr == lprc_pkg::ADDR_CTRL |=> ctrl == $past(wr_data))
      else $error("control write not stored");
   chk_low_write: assert property (
      wr_en && wr_addr == lprc_pkg::ADDR_LOW_HI |=> low_th[15:8] == $past(wr_data))
      else $error("low threshold high byte not stored");
   chk_flag_hold: assert property (
      |(status & ~clr_mask) |=> (status & $past(status & ~clr_mask))
      == $past(status & ~clr_mask))
      else $error("status flag dropped without a clear");
   chk_int_release: assert property (
      $fell(|status) |-> int_oe_b_o)
      else $error("interrupt pin held after flags cleared");
endmodule
`default_nettype wire

// ### verification/lprc_host.sv
`timescale 1ns/1ns
`default_nettype none
module lprc_host #(
   parameter logic [6:0] ADDR = lprc_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic mclk_i,
   input wire logic dev_sda_i,
   input wire logic dev_oe_b_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull_low = 1'b0;
   logic [15:0] nacks = 16'h0000;
   // Pull-up wins unless a party sinks the line
   assign sda_o = !(pull_low || (dev_oe_b_i === 1'b0 && dev_sda_i === 1'b0));
   initial scl_o = 1'b1;
   // ----------------------------------------
   // Bus phases, 2 or 4 core cycles each
   // ----------------------------------------
   task automatic wt(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   // Long wait before raising SCL: the device lets go of ACK late
   task automatic start();
      pull_low = 1'b0;
      wt(4);
      scl_o = 1'b1;
      wt(4);
      pull_low = 1'b1;
      wt(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      wt(2);
      pull_low = 1'b1;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      pull_low = 1'b0;
      wt(4);
   endtask
   // Sampled late in the high phase, as the device answers ~3 cycles after a fall
   task automatic xbyte(input logic [7:0] d, input logic nak, output logic [7:0] q,
                        output logic ak);
      logic [8:0] o;
      logic [8:0] r;
      o = {d, nak};
      for (int i = 8; i >= 0; i--) begin
         wt(2);
         pull_low = !o[i];
         wt(2);
         scl_o = 1'b1;
         wt(4);
         r[i] = sda_o;
         scl_o = 1'b0;
      end
      q = r[8:1];
      ak = r[0];
   endtask
   task automatic wb(input logic [7:0] d);
      logic [7:0] q;
      logic k;
      xbyte(d, 1'b1, q, k);
      nacks = nacks + {15'h0, k};
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      start();
      wb({ADDR, 1'b0});
      wb(a);
      wb(d);
      stop();
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      logic k;
      start();
      wb({ADDR, 1'b0});
      wb(a);
      start();
      wb({ADDR, 1'b1});
      xbyte(8'hFF, 1'b1, d, k);
      stop();
   endtask
endmodule
`default_nettype wire

// ### verification/lprc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module lprc_top_test;
   typedef struct packed {
      logic [7:0] ctrl;
      logic is_als;
      logic [15:0] val;
      logic [7:0] stat;
   } lprc_row_type;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic scl, sda, sda_o, sda_oe_b_o, int_o, int_oe_b_o;
   logic [15:0] als_result_i = 16'h0000;
   logic [15:0] prox_result_i = 16'h0000;
   logic als_done_i = 1'b0;
   logic prox_done_i = 1'b0;
   int err_total = 0;
   int num_checks = 0;
   logic [7:0] d;
   logic [15:0] exp_als = 16'h0000;
   logic [15:0] exp_prox = 16'h0000;
   logic [7:0] th [4] = '{8'h01, 8'h00, 8'h80, 8'h00};
   lprc_row_type rows [14] = '{'{8'h08, 1'b0, 16'h1234, 8'h08}, '{8'h04, 1'b1, 16'h5678, 8'h04},
      '{8'h04, 1'b0, 16'h2222, 8'h00}, '{8'h02, 1'b0, 16'h9000, 8'h01},
      '{8'h02, 1'b0, 16'h0050, 8'h02}, '{8'h02, 1'b1, 16'h9000, 8'h00},
      '{8'h03, 1'b1, 16'h9000, 8'h01}, '{8'h03, 1'b1, 16'h00FF, 8'h02},
      '{8'h03, 1'b0, 16'h0001, 8'h00}, '{8'h00, 1'b0, 16'h9000, 8'h00},
      '{8'h02, 1'b0, 16'h4000, 8'h00}, '{8'h02, 1'b0, 16'h8000, 8'h00},
      '{8'h02, 1'b0, 16'h0100, 8'h00}, '{8'h0E, 1'b0, 16'h8001, 8'h09}};
   always #4 mclk_i = ~mclk_i;
   lprc_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .int_o(int_o), .int_oe_b_o(int_oe_b_o),
      .als_result_i(als_result_i), .als_done_i(als_done_i),
      .prox_result_i(prox_result_i), .prox_done_i(prox_done_i));
   lprc_host host (.mclk_i(mclk_i), .dev_sda_i(sda_o), .dev_oe_b_i(sda_oe_b_o),
      .scl_o(scl), .sda_o(sda));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      host.reg_rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask
   // Second negedge keeps back-to-back pulses apart
   task automatic meas(input logic is_als, input logic [15:0] v);
      als_result_i = v;
      prox_result_i = v;
      als_done_i = is_als;
      prox_done_i = !is_als;
      @(negedge mclk_i);
      als_done_i = 1'b0;
      prox_done_i = 1'b0;
      @(negedge mclk_i);
      if (is_als) exp_als = v;
      else exp_prox = v;
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #800000;
      err_total++;
      summarize();
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      foreach (th[i]) host.reg_wr(8'h8A + 8'(i), th[i]);
      foreach (th[i]) rc(8'h8A + 8'(i), th[i]);
      $display("threshold test done");
      foreach (rows[i]) begin
         host.reg_wr(8'h8E, 8'h0F);
         host.reg_wr(8'h89, rows[i].ctrl);
         rc(8'h89, rows[i].ctrl);
         meas(rows[i].is_als, rows[i].val);
         rc(8'h8E, rows[i].stat);
         chk({15'h0, int_oe_b_o}, {15'h0, rows[i].stat == 8'h00});
         chk({15'h0, int_o}, 16'h0000);
         rc(8'h85, exp_als[15:8]);
         rc(8'h86, exp_als[7:0]);
         rc(8'h87, exp_prox[15:8]);
         rc(8'h88, exp_prox[7:0]);
         $display("row %0d done", i);
      end
      for (int a = 0; a < 4; a++) host.reg_wr(8'h85 + 8'(a), 8'hA5);
      rc(8'h85, exp_als[15:8]);
      rc(8'h86, exp_als[7:0]);
      rc(8'h87, exp_prox[15:8]);
      rc(8'h88, exp_prox[7:0]);
      $display("read-only test done");
      host.reg_wr(8'h8E, 8'h0F);
      host.reg_wr(8'h89, 8'h0C);
      meas(1'b1, 16'h0042);
      meas(1'b0, 16'h0043);
      host.reg_wr(8'h8E, 8'h00);
      rc(8'h8E, 8'h0C);
      host.reg_wr(8'h8E, 8'h04);
      rc(8'h8E, 8'h08);
      chk({15'h0, int_oe_b_o}, 16'h0000);
      host.reg_wr(8'h8E, 8'h08);
      chk({15'h0, int_oe_b_o}, 16'h0001);
      $display("sticky flag test done");
      for (int n = 0; n < 8; n++) begin
         host.reg_wr(8'h8E, 8'h0F);
         host.reg_wr(8'h89, {3'(n), 5'h02});
         repeat ((1 << n) - 1) meas(1'b0, 16'h9000);
         meas(1'b0, 16'h4000);
         repeat ((1 << n) - 1) meas(1'b0, 16'h9000);
         rc(8'h8E, 8'h00);
         meas(1'b0, 16'h9000);
         rc(8'h8E, 8'h01);
      end
      $display("persistence test done");
      rst_b_i = 1'b0;
      repeat (8) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      rc(8'h89, lprc_pkg::CTRL_RST);
      rc(8'h8E, lprc_pkg::STATUS_RST);
      for (int a = 0; a < 4; a++) rc(8'h85 + 8'(a), 8'h00);
      rc(8'h8C, lprc_pkg::HIGH_TH_RST[15:8]);
      chk({15'h0, int_oe_b_o}, 16'h0001);
      chk(host.nacks, 16'h0000);
      $display("reset test done");
      summarize();
   end
endmodule
`default_nettype wire
